//--- logic/timer_channel.sv
// Top of the 16-bit timer channel: registers, counter, compare, capture, output flop.
// Assumes a register master that never issues read and write together.
`timescale 1ns/1ns
module timer_channel #(
  parameter int CNT_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic debug_halt,
  input timer_channel_pkg::bus_req_t bus_req,
  output logic [31:0] rdata,
  input wire logic timer_input_pin,
  output logic timer_output_flipflop,
  output logic irq,
  output logic [2:0] dma_req
);
  import timer_channel_pkg::*;

  // Logic is written for the documented width only; refuse others at elaboration
  if (CNT_WIDTH != 16) begin : g_width_check
    $error("timer_channel supports CNT_WIDTH of 16 only");
  end

  // Registers
  logic [7:0] unit_enable_q;
  logic [7:0] run_control_q;
  logic [7:0] channel_control_q;
  logic [7:0] mode_select_q;
  logic [7:0] flipflop_control_q;
  logic [2:0] event_status_q;
  logic [2:0] interrupt_mask_q;
  logic [2:0] dma_request_enable_q;
  logic [15:0] compare_value_0_q; // Staging buffer
  logic [15:0] compare_value_1_q;
  logic [15:0] cmp_live_0_q; // Compared copy
  logic [15:0] cmp_live_1_q;
  logic [15:0] captured_value_0_q;
  logic [15:0] captured_value_1_q;
  logic [15:0] counter_q;
  logic [15:0] counter_d;
  logic [PRESCALER_WIDTH-1:0] prescaler_q;
  logic [PRESCALER_WIDTH-1:0] prescaler_d;
  logic prescaler_tap_q;
  logic pin_last_q;
  logic flop_last_q;
  run_state_t state_q;
  run_state_t state_d;
  logic pin_level;

  // Synchronised pin
  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(timer_input_pin),
    .level(pin_level)
  );

  // Control decode
  wire unit_on = unit_enable_q[BIT_UNIT_CLOCK_GATE];
  // Debug halt freezes counting when the freeze bit is set
  wire halted = unit_enable_q[BIT_DEBUG_FREEZE] & debug_halt;
  wire tick_en = clk_en & unit_on & ~halted;
  wire prescaler_run = run_control_q[BIT_PRESCALER_RUN];
  wire counter_run = run_control_q[BIT_COUNTER_RUN];
  wire double_buffer = channel_control_q[BIT_DOUBLE_BUFFER];
  wire trigger_fall = channel_control_q[BIT_TRIGGER_EDGE_SELECT];
  wire start_ext = channel_control_q[BIT_START_SOURCE_SELECT];
  wire [1:0] capture_edge_select = mode_select_q[BIT_CAPTURE_EDGE_LO +: 2];
  wire match_clear_enable = mode_select_q[BIT_MATCH_CLEAR_ENABLE];
  wire [2:0] clock_source = mode_select_q[BIT_CLOCK_SOURCE_LO +: 3];

  // Bus decode; other registers gated while unit is off
  wire hit_en = bus_req.addr == OFF_UNIT_ENABLE;
  wire wr_en = bus_req.wr & hit_en;
  wire wr_ok = bus_req.wr & unit_on & clk_en;
  wire wr_run = wr_ok & (bus_req.addr == OFF_RUN_CONTROL);
  wire wr_ctl = wr_ok & (bus_req.addr == OFF_CHANNEL_CONTROL);
  wire wr_mod = wr_ok & (bus_req.addr == OFF_MODE_SELECT);
  wire wr_ffc = wr_ok & (bus_req.addr == OFF_FLIPFLOP_CONTROL);
  wire wr_st = wr_ok & (bus_req.addr == OFF_EVENT_STATUS);
  wire wr_im = wr_ok & (bus_req.addr == OFF_INTERRUPT_MASK);
  wire wr_rg0 = wr_ok & (bus_req.addr == OFF_COMPARE_VALUE_0);
  wire wr_rg1 = wr_ok & (bus_req.addr == OFF_COMPARE_VALUE_1);
  wire wr_dma = wr_ok & (bus_req.addr == OFF_DMA_REQUEST_ENABLE);
  // Writing zero to the soft capture bit grabs the counter
  wire soft_capture = wr_mod & ~bus_req.wdata[BIT_SOFT_CAPTURE];

  // Prescaler tap: bit selected by clock source code
  wire [2:0] tap_idx = clock_source - 3'h1;
  wire tap_now = prescaler_q[tap_idx];
  wire prescale_edge = prescaler_run & tap_now & ~prescaler_tap_q;
  // Event counter mode counts synchronised pin rising edges
  wire pin_rise = pin_level & ~pin_last_q;
  wire pin_fall = ~pin_level & pin_last_q;
  wire flop_rise = timer_output_flipflop & ~flop_last_q;
  wire flop_fall = ~timer_output_flipflop & flop_last_q;
  wire count_tick = (clock_source == SRC_PIN) ? pin_rise : prescale_edge;
  wire trigger_edge = trigger_fall ? pin_fall : pin_rise;

  // Comparators against the live compare values
  wire counting = state_q == ST_COUNT;
  wire match0 = counting & count_tick & (counter_q == cmp_live_0_q);
  wire match1 = counting & count_tick & (counter_q == cmp_live_1_q);
  wire overflow = counting & count_tick & (counter_q == 16'hffff);

  // Capture sources
  wire cap_pin = capture_edge_select == CAP_PIN;
  wire cap_flop = capture_edge_select == CAP_FLOP;
  wire cap0 = soft_capture | (cap_pin & pin_rise) | (cap_flop & flop_rise);
  wire cap1 = (cap_pin & pin_fall) | (cap_flop & flop_fall);

  // Run state: software start or waiting for trigger
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (counter_run) begin
          state_d = start_ext ? ST_ARMED : ST_COUNT;
        end
      end
      ST_ARMED: begin
        if (!counter_run) begin
          state_d = ST_IDLE;
        end else if (trigger_edge) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!counter_run) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Counter next value: stop-clear, match clear, or increment
  always_comb begin
    counter_d = counter_q;
    if (!counter_run) begin
      counter_d = 16'h0000;
    end else if (match1 && match_clear_enable) begin
      counter_d = 16'h0000;
    end else if (counting && count_tick) begin
      counter_d = counter_q + 16'h0001;
    end
  end

  // Prescaler next value: stop-clear while off
  always_comb begin
    prescaler_d = prescaler_q;
    if (!prescaler_run) begin
      prescaler_d = '0;
    end else begin
      prescaler_d = prescaler_q + 1'b1;
    end
  end

  // Enable register stays reachable always
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      unit_enable_q <= RST_ZERO[7:0];
    end else if (clk_en && wr_en) begin
      unit_enable_q <= bus_req.wdata[7:0] & MASK_UNIT_ENABLE;
    end
  end

  // Control registers; all hold while unit is off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_control_q <= RST_ZERO[7:0];
      channel_control_q <= RST_ZERO[7:0];
      mode_select_q <= RST_MODE_SELECT;
      interrupt_mask_q <= RST_ZERO[2:0];
      dma_request_enable_q <= RST_ZERO[2:0];
    end else begin
      if (wr_run) run_control_q <= bus_req.wdata[7:0] & MASK_RUN_CONTROL;
      if (wr_ctl) channel_control_q <= bus_req.wdata[7:0] & MASK_CHANNEL_CONTROL;
      // Soft capture bit always reads one
      if (wr_mod) mode_select_q <= (bus_req.wdata[7:0] & MASK_MODE_SELECT) | RST_MODE_SELECT;
      if (wr_im) interrupt_mask_q <= bus_req.wdata[2:0] & MASK_EVENTS;
      if (wr_dma) dma_request_enable_q <= bus_req.wdata[2:0] & MASK_EVENTS;
    end
  end

  // Compare staging; live copy loads on clear match, while idle, or at once
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_value_0_q <= RST_COMPARE;
      compare_value_1_q <= RST_COMPARE;
      cmp_live_0_q <= RST_COMPARE;
      cmp_live_1_q <= RST_COMPARE;
    end else begin
      if (wr_rg0) compare_value_0_q <= bus_req.wdata[15:0];
      if (wr_rg1) compare_value_1_q <= bus_req.wdata[15:0];
      if (tick_en && (!double_buffer || state_q == ST_IDLE || (match1 && match_clear_enable))) begin
        cmp_live_0_q <= wr_rg0 ? bus_req.wdata[15:0] : compare_value_0_q;
        cmp_live_1_q <= wr_rg1 ? bus_req.wdata[15:0] : compare_value_1_q;
      end
    end
  end

  // Timing logic runs only while clocked and enabled
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      counter_q <= 16'h0000;
      prescaler_q <= '0;
      prescaler_tap_q <= 1'b0;
      pin_last_q <= 1'b0;
      flop_last_q <= 1'b0;
    end else if (tick_en) begin
      state_q <= state_d;
      counter_q <= counter_d;
      prescaler_q <= prescaler_d;
      prescaler_tap_q <= tap_now;
      pin_last_q <= pin_level;
      flop_last_q <= timer_output_flipflop;
    end
  end

  // Capture latches; values kept for frequency and width math
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_value_0_q <= 16'h0000;
      captured_value_1_q <= 16'h0000;
    end else if (tick_en) begin
      if (cap0) captured_value_0_q <= counter_q;
      if (cap1) captured_value_1_q <= counter_q;
    end
  end

  // Output flop: soft command on write, toggles on chosen events
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flipflop_control_q <= RST_FLIPFLOP_CONTROL;
      timer_output_flipflop <= 1'b0;
    end else if (tick_en) begin
      if (wr_ffc) begin
        // Command field returns to no-op after acting
        flipflop_control_q <= (bus_req.wdata[7:0] & MASK_FLIPFLOP_CONTROL) | RST_FLIPFLOP_CONTROL;
        case (bus_req.wdata[BIT_FF_CMD_LO +: 2])
          FF_CMD_INVERT: timer_output_flipflop <= ~timer_output_flipflop;
          FF_CMD_SET: timer_output_flipflop <= 1'b1;
          FF_CMD_CLEAR: timer_output_flipflop <= 1'b0;
          default: timer_output_flipflop <= timer_output_flipflop;
        endcase
      end else if ((match0 & flipflop_control_q[BIT_FF_INV_MATCH0]) ^
                   (match1 & flipflop_control_q[BIT_FF_INV_MATCH1]) ^
                   (cap0 & flipflop_control_q[BIT_FF_INV_CAP0]) ^
                   (cap1 & flipflop_control_q[BIT_FF_INV_CAP1])) begin
        // Pulse pattern: enabled match 0, match 1, capture 0 and capture 1 edges toggle it, XOR combined
        timer_output_flipflop <= ~timer_output_flipflop;
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  wire [2:0] events = {overflow, match1, match0} & {3{tick_en}};
  wire [2:0] st_clear = wr_st ? bus_req.wdata[2:0] : 3'h0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_status_q <= RST_ZERO[2:0];
    end else begin
      event_status_q <= (event_status_q & ~st_clear) | events;
    end
  end

  // Interrupt and dma request outputs from flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      dma_req <= 3'h0;
    end else if (clk_en) begin
      irq <= |(event_status_q & interrupt_mask_q);
      dma_req <= events & dma_request_enable_q;
    end
  end

  // Read mux; unmapped and gated addresses read zero
  wire rd_ok = unit_on | hit_en;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (!rd_ok) rd_mux = 32'h0000_0000;
    else if (bus_req.addr == OFF_UNIT_ENABLE) rd_mux = {24'h00_0000, unit_enable_q};
    else if (bus_req.addr == OFF_RUN_CONTROL) rd_mux = {24'h00_0000, run_control_q};
    else if (bus_req.addr == OFF_CHANNEL_CONTROL) rd_mux = {24'h00_0000, channel_control_q};
    else if (bus_req.addr == OFF_MODE_SELECT) rd_mux = {24'h00_0000, mode_select_q};
    else if (bus_req.addr == OFF_FLIPFLOP_CONTROL) rd_mux = {24'h00_0000, flipflop_control_q};
    else if (bus_req.addr == OFF_EVENT_STATUS) rd_mux = {29'h0000_0000, event_status_q};
    else if (bus_req.addr == OFF_INTERRUPT_MASK) rd_mux = {29'h0000_0000, interrupt_mask_q};
    else if (bus_req.addr == OFF_COUNTER_SNAPSHOT) rd_mux = {16'h0000, counter_q};
    else if (bus_req.addr == OFF_COMPARE_VALUE_0) rd_mux = {16'h0000, compare_value_0_q};
    else if (bus_req.addr == OFF_COMPARE_VALUE_1) rd_mux = {16'h0000, compare_value_1_q};
    else if (bus_req.addr == OFF_CAPTURED_VALUE_0) rd_mux = {16'h0000, captured_value_0_q};
    else if (bus_req.addr == OFF_CAPTURED_VALUE_1) rd_mux = {16'h0000, captured_value_1_q};
    else if (bus_req.addr == OFF_DMA_REQUEST_ENABLE) rd_mux = {29'h0000_0000, dma_request_enable_q};
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= bus_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Checks
  sequence s_run_off;
    tick_en && !counter_run;
  endsequence

  chk_stop_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_run_off |=> counter_q == 16'h0000) else $error("counter not cleared when stopped");
  chk_prescale_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick_en && !prescaler_run |=> prescaler_q == '0) else $error("prescaler not cleared");
  chk_gate_blocks: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus_req.wr && !unit_on && !hit_en |=> $stable(run_control_q) && $stable(compare_value_1_q))
    else $error("write passed while unit off");
  chk_gate_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && bus_req.rd && !unit_on && !hit_en |=> rdata == 32'h0000_0000)
    else $error("read passed while unit off");
  chk_hold_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    !unit_on |=> $stable(counter_q) && $stable(mode_select_q)) else $error("state changed while off");
  chk_halt_freeze: assert property (@(posedge core_clk) disable iff (!reset_n)
    halted |=> $stable(counter_q)) else $error("counter moved in debug halt");
  chk_match_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick_en && match1 && match_clear_enable && counter_run |=> counter_q == 16'h0000)
    else $error("match clear missing");
  chk_capture_take: assert property (@(posedge core_clk) disable iff (!reset_n)
    tick_en && cap0 |=> captured_value_0_q == $past(counter_q)) else $error("capture 0 wrong");
  chk_armed_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_ARMED && !trigger_edge |=> counter_q == 16'h0000) else $error("counted before trigger");
  chk_irq_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    clk_en && |(event_status_q & interrupt_mask_q) |=> irq) else $error("irq missing");
  chk_sticky_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    events != 3'h0 |=> (event_status_q & $past(events)) == $past(events)) else $error("event lost");
  chk_dbuf_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    counting && double_buffer && !match1 |=> $stable(cmp_live_1_q)) else $error("live compare changed");
endmodule

//--- logic/timer_channel_pkg.sv
// Constants, field positions and carrier types for the 16-bit timer channel.
// Assumes a plain one-cycle register port and a single core clock.
package timer_channel_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_UNIT_ENABLE = 8'h00;
  localparam logic [7:0] OFF_RUN_CONTROL = 8'h04;
  localparam logic [7:0] OFF_CHANNEL_CONTROL = 8'h08;
  localparam logic [7:0] OFF_MODE_SELECT = 8'h0c;
  localparam logic [7:0] OFF_FLIPFLOP_CONTROL = 8'h10;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h14;
  localparam logic [7:0] OFF_INTERRUPT_MASK = 8'h18;
  localparam logic [7:0] OFF_COUNTER_SNAPSHOT = 8'h1c;
  localparam logic [7:0] OFF_COMPARE_VALUE_0 = 8'h20;
  localparam logic [7:0] OFF_COMPARE_VALUE_1 = 8'h24;
  localparam logic [7:0] OFF_CAPTURED_VALUE_0 = 8'h28;
  localparam logic [7:0] OFF_CAPTURED_VALUE_1 = 8'h2c;
  localparam logic [7:0] OFF_DMA_REQUEST_ENABLE = 8'h30;
  // Field positions
  localparam int BIT_UNIT_CLOCK_GATE = 7;
  localparam int BIT_DEBUG_FREEZE = 6;
  localparam int BIT_PRESCALER_RUN = 2;
  localparam int BIT_COUNTER_RUN = 0;
  localparam int BIT_DOUBLE_BUFFER = 7;
  localparam int BIT_TRIGGER_EDGE_SELECT = 1;
  localparam int BIT_START_SOURCE_SELECT = 0;
  localparam int BIT_SOFT_CAPTURE = 6;
  localparam int BIT_CAPTURE_EDGE_LO = 4;
  localparam int BIT_MATCH_CLEAR_ENABLE = 3;
  localparam int BIT_CLOCK_SOURCE_LO = 0;
  // Flip-flop control layout: bits 1:0 soft command, 2 invert on match 0,
  // 3 invert on match 1, 4 invert on capture 0, 5 invert on capture 1
  localparam int BIT_FF_CMD_LO = 0;
  localparam int BIT_FF_INV_MATCH0 = 2;
  localparam int BIT_FF_INV_MATCH1 = 3;
  localparam int BIT_FF_INV_CAP0 = 4;
  localparam int BIT_FF_INV_CAP1 = 5;
  // Status and mask layout
  localparam int BIT_EV_MATCH0 = 0;
  localparam int BIT_EV_MATCH1 = 1;
  localparam int BIT_EV_OVERFLOW = 2;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_MODE_SELECT = 8'h40;
  localparam logic [7:0] RST_FLIPFLOP_CONTROL = 8'h03;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  // Write masks of used bits
  localparam logic [7:0] MASK_UNIT_ENABLE = 8'hc0;
  localparam logic [7:0] MASK_RUN_CONTROL = 8'h05;
  localparam logic [7:0] MASK_CHANNEL_CONTROL = 8'h83;
  localparam logic [7:0] MASK_MODE_SELECT = 8'h3f;
  localparam logic [7:0] MASK_FLIPFLOP_CONTROL = 8'h3f;
  localparam logic [2:0] MASK_EVENTS = 3'h7;
  // Capture timing encodings
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_PIN = 2'h2;
  localparam logic [1:0] CAP_FLOP = 2'h3;
  // Flip-flop soft commands
  localparam logic [1:0] FF_CMD_INVERT = 2'h0;
  localparam logic [1:0] FF_CMD_SET = 2'h1;
  localparam logic [1:0] FF_CMD_CLEAR = 2'h2;
  // Clock source codes: 0 pin events, else prescaler tap
  localparam logic [2:0] SRC_PIN = 3'h0;
  localparam int PRESCALER_WIDTH = 8;

  // Run state of the counter
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_COUNT = 2'b10
  } run_state_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

//--- logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ns
module pin_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Chain; first stage read only by the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted once stages two and three agree
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end
endmodule

//--- dv/timer_event_counter_16bit_tb.sv
// Self-checking bench for the 16-bit timer channel: registers, counting, match, irq, capture.
// Assumes the package and design files compile first and a single 10 MHz core clock.
`timescale 1ns/1ns
module timer_event_counter_16bit_tb;
  import timer_channel_pkg::*;
  logic core_clk = 1'b0; // Bench clock
  logic reset_n = 1'b0; // Held low for 20 cycles
  logic clk_en = 1'b1; // Always running here
  logic debug_halt = 1'b0; // Driven in the freeze test
  bus_req_t bus_req = '0; // Register port request
  logic [31:0] rdata;
  logic timer_input_pin = 1'b0; // Event and trigger source
  logic timer_output_flipflop;
  logic irq;
  logic [2:0] dma_req;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0; // Watchdog count
  int dma_cnt = 0; // Dma request pulses seen
  logic [31:0] rd_q; // Last word read
  logic [31:0] held; // Frozen counter value
  logic [15:0] lim; // Random match-1 limit
  logic [15:0] hit; // Random match-0 point

  timer_channel #(.CNT_WIDTH(16)) DUT (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .debug_halt(debug_halt),
    .bus_req(bus_req),
    .rdata(rdata),
    .timer_input_pin(timer_input_pin),
    .timer_output_flipflop(timer_output_flipflop),
    .irq(irq),
    .dma_req(dma_req)
  );

  // Clock: 50 ns half period
  always #50 core_clk = ~core_clk;

  // Watchdog; the whole sequence needs at most about 705 cycles. Also counts dma pulses.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (dma_req != 3'h0) begin
      dma_cnt <= dma_cnt + 1;
    end
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  // Expected readback of a byte-wide register with its used bits
  function automatic logic [31:0] field(input logic [31:0] v, input logic [7:0] m);
    return {24'h00_0000, v[7:0] & m};
  endfunction

  // Expected status word
  function automatic logic [31:0] ev(input logic m0, input logic m1, input logic ov);
    return {29'h0000_0000, ov, m1, m0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One-cycle write strobe; a fresh edge before each so strobes never collide
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe; the next edge still sees it
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(posedge core_clk);
    rd_q = rdata;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    chk(rd_q, exp, what);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(58));
    lim = 16'($urandom_range(40, 8));
    hit = 16'($urandom_range(7, 1));
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    // Gated unit: only the enable word answers
    reg_rd(OFF_UNIT_ENABLE, RST_ZERO, "enable reset");
    reg_rd(OFF_RUN_CONTROL, RST_ZERO, "run reset");
    reg_wr(OFF_COMPARE_VALUE_1, 32'h0000_1234);
    reg_rd(OFF_MODE_SELECT, RST_ZERO, "gated read");
    reg_wr(OFF_UNIT_ENABLE, 32'hFFFF_FFFF);
    reg_rd(OFF_UNIT_ENABLE, field(32'hFFFF_FFFF, MASK_UNIT_ENABLE), "enable bits");
    reg_rd(OFF_COMPARE_VALUE_1, RST_ZERO, "gated write");
    reg_wr(OFF_UNIT_ENABLE, 32'h0000_0080);
    reg_rd(OFF_MODE_SELECT, {24'h00_0000, RST_MODE_SELECT}, "mode reset");
    reg_rd(OFF_FLIPFLOP_CONTROL, {24'h00_0000, RST_FLIPFLOP_CONTROL}, "ff reset");
    reg_rd(8'h40, RST_ZERO, "unmapped");
    for (int i = 0; i < 8; i++) begin
      rd_q = $urandom;
      reg_wr(OFF_COMPARE_VALUE_0, rd_q);
      reg_rd(OFF_COMPARE_VALUE_0, {16'h0000, rd_q[15:0]}, "compare readback");
    end
    $display("test registers done");
    // Interval timing: prescaler tap 0, clear on match 1
    reg_wr(OFF_COMPARE_VALUE_0, {16'h0000, hit});
    reg_wr(OFF_COMPARE_VALUE_1, {16'h0000, lim});
    reg_wr(OFF_MODE_SELECT, 32'h0000_0049);
    reg_rd(OFF_MODE_SELECT, field(32'h0000_0049, MASK_MODE_SELECT) | 32'h0000_0040, "mode");
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0005);
    idle(4 * lim + 20);
    reg_rd(OFF_EVENT_STATUS, ev(1'b1, 1'b1, 1'b0), "match events");
    repeat (6) begin
      rd(OFF_COUNTER_SNAPSHOT);
      chk({31'h0000_0000, rd_q <= {16'h0000, lim}}, 32'h0000_0001, "past limit");
    end
    chk({31'h0000_0000, irq}, 32'h0000_0000, "masked irq");
    reg_wr(OFF_INTERRUPT_MASK, 32'h0000_0002);
    idle(2);
    chk({31'h0000_0000, irq}, 32'h0000_0001, "irq raised");
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0004);
    reg_rd(OFF_COUNTER_SNAPSHOT, RST_ZERO, "stop clears");
    reg_wr(OFF_EVENT_STATUS, 32'h0000_0003);
    idle(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
    reg_rd(OFF_EVENT_STATUS, RST_ZERO, "status cleared");
    // Gating off must not lose settings
    reg_wr(OFF_UNIT_ENABLE, RST_ZERO);
    reg_wr(OFF_UNIT_ENABLE, 32'h0000_0080);
    reg_rd(OFF_COMPARE_VALUE_1, {16'h0000, lim}, "kept limit");
    reg_rd(OFF_INTERRUPT_MASK, 32'h0000_0002, "kept mask");
    $display("test interval done");
    // Debug freeze holds the count; a soft capture then copies it
    reg_wr(OFF_UNIT_ENABLE, 32'h0000_00C0);
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0005);
    idle(7);
    debug_halt <= 1'b1;
    idle(3);
    rd(OFF_COUNTER_SNAPSHOT);
    held = rd_q;
    idle(10);
    reg_rd(OFF_COUNTER_SNAPSHOT, held, "frozen count");
    chk({31'h0000_0000, held != 0}, 32'h0000_0001, "count moved");
    // Capture needs a running clock: stop the prescaler so the count holds, then release halt
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0001);
    debug_halt <= 1'b0;
    reg_wr(OFF_MODE_SELECT, 32'h0000_0009);
    reg_rd(OFF_CAPTURED_VALUE_0, held, "soft capture");
    $display("test freeze done");
    // Event counting on pin rising edges; pin edges captured; match 0 requests dma
    reg_wr(OFF_RUN_CONTROL, RST_ZERO);
    reg_wr(OFF_MODE_SELECT, 32'h0000_0060);
    reg_wr(OFF_DMA_REQUEST_ENABLE, 32'h0000_0001);
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0001);
    repeat (5) begin
      timer_input_pin <= 1'b1;
      idle(8);
      timer_input_pin <= 1'b0;
      idle(8);
    end
    reg_rd(OFF_COUNTER_SNAPSHOT, 32'h0000_0005, "pin events");
    // Last rise sees count 4 before it steps, last fall sees 5
    reg_rd(OFF_CAPTURED_VALUE_0, 32'h0000_0004, "rise capture");
    reg_rd(OFF_CAPTURED_VALUE_1, 32'h0000_0005, "fall capture");
    // Counts 0 to 4 pass the pin ticks, so match 0 fires once only if hit is below 5
    chk(dma_cnt, (hit < 5) ? 32'h0000_0001 : 32'h0000_0000, "dma pulses");
    // Triggered start with double buffer: nothing counts until the rising edge
    reg_wr(OFF_RUN_CONTROL, RST_ZERO);
    reg_wr(OFF_CHANNEL_CONTROL, 32'h0000_0081);
    reg_wr(OFF_MODE_SELECT, 32'h0000_0049);
    reg_wr(OFF_RUN_CONTROL, 32'h0000_0005);
    idle(20);
    reg_rd(OFF_COUNTER_SNAPSHOT, RST_ZERO, "armed idle");
    timer_input_pin <= 1'b1;
    idle(10);
    rd(OFF_COUNTER_SNAPSHOT);
    chk({31'h0000_0000, rd_q != 0}, 32'h0000_0001, "triggered run");
    // Staged limit of 1 waits for the next clear at lim; an early load would let the count run away
    reg_wr(OFF_COMPARE_VALUE_1, 32'h0000_0001);
    idle(4 * lim + 20);
    rd(OFF_COUNTER_SNAPSHOT);
    chk({31'h0000_0000, rd_q <= 32'h0000_0001}, 32'h0000_0001, "staged limit");
    reg_wr(OFF_RUN_CONTROL, RST_ZERO);
    $display("test start done");
    // Soft output commands: set, clear, invert
    reg_wr(OFF_FLIPFLOP_CONTROL, 32'h0000_0001);
    idle(2);
    chk({31'h0000_0000, timer_output_flipflop}, 32'h0000_0001, "ff set");
    reg_wr(OFF_FLIPFLOP_CONTROL, 32'h0000_0002);
    idle(2);
    chk({31'h0000_0000, timer_output_flipflop}, 32'h0000_0000, "ff clear");
    reg_wr(OFF_FLIPFLOP_CONTROL, 32'h0000_0000);
    idle(2);
    chk({31'h0000_0000, timer_output_flipflop}, 32'h0000_0001, "ff invert");
    $display("test flipflop done");
    test_done();
  end
endmodule
